// ---- hdl/scc_map.vh ----
`ifndef SCC_MAP_VH
`define SCC_MAP_VH

// register word indices, byte address is four times the index
`define SCC_IDX_OPTION      20'h000c2
`define SCC_IDX_HOCO_DIVIDER_SELECT     20'hf00a8
`define SCC_IDX_MODE        20'hf00a0
`define SCC_IDX_STABSEL     20'hf00a1
`define SCC_IDX_RUN         20'hf00a2
`define SCC_IDX_STABCNT     20'hf00a3
`define SCC_IDX_SYSCLK      20'hf00a4
`define SCC_IDX_SUBSUP      20'hf00a5

// osc_mode_control fields
`define SCC_MODE_MAIN_EXT   7
`define SCC_MODE_MAIN_PIN   6
`define SCC_MODE_SUB_EXT    5
`define SCC_MODE_SUB_PIN    4
`define SCC_MODE_SUB_DRV_HI 2
`define SCC_MODE_SUB_DRV_LO 1
`define SCC_MODE_MAIN_GAIN  0

// osc_run_control fields
`define SCC_RUN_MAIN_STOP   7
`define SCC_RUN_SUB_STOP    6
`define SCC_RUN_HOCO_STOP   0

// system_clock_control fields
`define SCC_SYS_SUB_STAT    7
`define SCC_SYS_SUB_SEL     6
`define SCC_SYS_MAIN_STAT   5
`define SCC_SYS_MAIN_SEL    4

// sub_supply_mode_control fields
`define SCC_SUP_LOWPWR      7
`define SCC_SUP_LSTMR       4

// option byte fields and codes
`define SCC_OPT_MODE_HI     7
`define SCC_OPT_MODE_LO     6
`define SCC_OPT_FIX1        5
`define SCC_OPT_FIX0        4
`define SCC_OPT_FAM         3
`define SCC_FLASH_LS        2'h2
`define SCC_FLASH_HS        2'h3

// reset values
`define SCC_RST_MAIN_STOP   1'b1
`define SCC_RST_SUB_STOP    1'b1
`define SCC_RST_HOCO_STOP   1'b0
`define SCC_RST_STABSEL     3'h7
`define SCC_RST_HOCO_DIVIDER_SELECT     3'h0

// clock source codes
`define SCC_SRC_HOCO        2'h0
`define SCC_SRC_MAIN        2'h1
`define SCC_SRC_SUB         2'h2

// timing: system clock rate and stabilisation thresholds (log2 of main clock counts)
`define SCC_SYS_MHZ         7'd100
`define SCC_STAB_MAX        19'h40000
`define SCC_EXP0            5'd8
`define SCC_EXP1            5'd9
`define SCC_EXP2            5'd10
`define SCC_EXP3            5'd11
`define SCC_EXP4            5'd13
`define SCC_EXP5            5'd15
`define SCC_EXP6            5'd17
`define SCC_EXP7            5'd18

`endif

// ---- hdl/scc_clk_switch.v ----
`timescale 1ns/100ps
`include "scc_map.vh"

module scc_clk_switch (
	// system
	input  wire       clk_sys,
	input  wire       nrst,
	// source request and edges
	input  wire [1:0] srcReq,
	input  wire [2:0] srcEdge,
	// selected clock
	output reg        clkEn,
	output reg  [1:0] srcCur,
	output wire       busy
);

	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_OLD  = 3'b010;
	localparam [2:0] ST_NEW  = 3'b100;

	reg [2:0] stateReg;
	reg [2:0] stateNext;
	reg [1:0] tgtReg;
	reg [1:0] tgtNext;
	reg [1:0] curNext;
	reg       enNext;

	// edge pulse of one source, code 3 never carries a clock
	function edgeOf;
		input [2:0] e;
		input [1:0] s;
		begin
			edgeOf = (s == 2'h3) ? 1'b0 : e[s];
		end
	endfunction

	assign busy = ~stateReg[0];

	// hand over only after the old clock finished a period and the new one delivered an edge
	always @* begin
		stateNext = stateReg;
		tgtNext   = tgtReg;
		curNext   = srcCur;
		enNext    = 1'b0;
		case (stateReg)
			ST_IDLE: begin
				enNext = edgeOf(srcEdge, srcCur);
				if (srcReq != srcCur) begin
					stateNext = ST_OLD;
				end
			end
			ST_OLD: begin
				enNext = edgeOf(srcEdge, srcCur);
				if (srcReq == srcCur) begin
					stateNext = ST_IDLE;
				end else if (edgeOf(srcEdge, srcCur)) begin
					tgtNext   = srcReq;
					stateNext = ST_NEW;
				end
			end
			ST_NEW: begin
				// no pulses here, so no short period reaches the cpu
				if (edgeOf(srcEdge, tgtReg)) begin
					curNext   = tgtReg;
					stateNext = ST_IDLE;
				end
			end
			default: begin
				stateNext = ST_IDLE;
			end
		endcase
	end

	// state and outputs, the internal oscillator is the source out of reset
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			stateReg <= ST_IDLE;
			tgtReg   <= `SCC_SRC_HOCO;
			srcCur   <= `SCC_SRC_HOCO;
			clkEn    <= 1'b0;
		end else begin
			stateReg <= stateNext;
			tgtReg   <= tgtNext;
			srcCur   <= curNext;
			clkEn    <= enNext;
		end
	end

endmodule

// ---- hdl/scc_top.v ----
// Our own choice: the APB register port.
`timescale 1ns/100ps
`include "scc_map.vh"


module scc_top (
	// system
	input  wire        clk_sys,
	input  wire        nrst,
	input  wire        porN,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [21:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	// nonvolatile option byte
	input  wire [7:0]  optionByte,
	// oscillator pins, sampled
	input  wire        mainClkIn,
	input  wire        subClkIn,
	// power state
	input  wire        stopMode,
	input  wire        haltMode,
	input  wire        wdtRunning,
	// oscillator controls
	output reg         mainXtalEnable,
	output reg         mainExtEnable,
	output reg         mainHighGain,
	output reg         subXtalEnable,
	output reg         subExtEnable,
	output reg  [1:0]  subDriveMode,
	output reg         hocoEnable,
	output reg         lowOscEnable,
	output reg  [4:0]  hocoFreqMhz,
	output reg         flashHighSpeed,
	output reg         optionError,
	// clock enables
	output wire        cpuClkEn,
	output wire [1:0]  cpuClkSrc,
	output reg         subPeriphClkEn,
	output reg         subCoreClkEn
);

	localparam H_OPT = 0;
	localparam H_DIV = 1;
	localparam H_MODE = 2;
	localparam H_SSEL = 3;
	localparam H_RUN = 4;
	localparam H_SCNT = 5;
	localparam H_SYS = 6;
	localparam H_SUP = 7;

	// internal oscillator frequency in MHz, zero marks a prohibited setting
	function [4:0] hocoMhz;
		input       fam;
		input [2:0] div;
		begin
			case ({fam, div})
				4'h0: hocoMhz = 5'd24;
				4'h1: hocoMhz = 5'd12;
				4'h2: hocoMhz = 5'd6;
				4'h3: hocoMhz = 5'd3;
				4'h9: hocoMhz = 5'd16;
				4'ha: hocoMhz = 5'd8;
				4'hb: hocoMhz = 5'd4;
				4'hc: hocoMhz = 5'd2;
				4'hd: hocoMhz = 5'd1;
				default: hocoMhz = 5'd0;
			endcase
		end
	endfunction

	// log2 of main clock counts for each threshold step
	function [4:0] stabExp;
		input [2:0] k;
		begin
			case (k)
				3'h0: stabExp = `SCC_EXP0;
				3'h1: stabExp = `SCC_EXP1;
				3'h2: stabExp = `SCC_EXP2;
				3'h3: stabExp = `SCC_EXP3;
				3'h4: stabExp = `SCC_EXP4;
				3'h5: stabExp = `SCC_EXP5;
				3'h6: stabExp = `SCC_EXP6;
				default: stabExp = `SCC_EXP7;
			endcase
		end
	endfunction

	reg        mainExtReg;
	reg        mainPinReg;
	reg        mainGainReg;
	reg        modeWrittenReg;
	reg        subExtReg;
	reg        subPinReg;
	reg [1:0]  subDrvReg;
	reg        subStopReg;
	reg        mainStopReg;
	reg        hocoStopReg;
	reg [2:0]  stabSelReg;
	reg        famReg;
	reg [2:0]  hocoDivReg;
	reg [7:0]  optReg;
	reg        loadedReg;
	reg        cpuSubSelReg;
	reg        mainSelReg;
	reg        lowPwrReg;
	reg        lsTmrReg;
	reg [2:0]  mainSyncReg;
	reg [2:0]  subSyncReg;
	reg [18:0] stabCntReg;
	reg        mainRunDlyReg;
	reg        stopDlyReg;
	reg        mainHoldReg;
	reg [6:0]  accReg;
	reg        hocoPulseReg;
	reg [7:0]  hitVec;
	reg [7:0]  rdByte;
	wire [7:0] stabFlags;
	wire [19:0] regIdx = paddr[21:2];
	wire       wrEn = psel & penable & pwrite;
	wire       wrByte0 = wrEn & pstrb[0];
	wire       wrMode = wrEn & hitVec[H_MODE] & (pstrb == 4'h1) & ~modeWrittenReg;
	wire       mainXtalRun = mainPinReg & ~mainExtReg & ~mainStopReg;
	wire       mainExtRun = mainPinReg & mainExtReg & ~mainStopReg;
	wire       subRun = subPinReg & ~subStopReg;
	wire       stabRestart = (mainXtalRun & ~mainRunDlyReg) | (stopMode & ~stopDlyReg);
	wire [18:0] stabLimit = `SCC_STAB_MAX >> (5'd18 - stabExp(stabSelReg));
	wire [7:0] accSum = {1'b0, accReg} + {3'h0, hocoMhz(famReg, hocoDivReg)};
	wire       mainEdge = mainSyncReg[1] & ~mainSyncReg[2];
	wire       subEdge = subSyncReg[1] & ~subSyncReg[2];
	wire       mainEdgeOk = mainEdge & ((mainXtalRun & ~mainHoldReg) | mainExtRun);
	wire       subEdgeOk = subEdge & subRun;
	wire [1:0] srcReq = cpuSubSelReg ? `SCC_SRC_SUB : (mainSelReg ? `SCC_SRC_MAIN : `SCC_SRC_HOCO);

	assign pready = 1'b1;

	// address decode, one bit per register
	always @* begin
		hitVec = 8'h00;
		if (regIdx == `SCC_IDX_OPTION) begin
			hitVec[H_OPT] = 1'b1;
		end else if (regIdx == `SCC_IDX_HOCO_DIVIDER_SELECT) begin
			hitVec[H_DIV] = 1'b1;
		end else if (regIdx == `SCC_IDX_MODE) begin
			hitVec[H_MODE] = 1'b1;
		end else if (regIdx == `SCC_IDX_STABSEL) begin
			hitVec[H_SSEL] = 1'b1;
		end else if (regIdx == `SCC_IDX_RUN) begin
			hitVec[H_RUN] = 1'b1;
		end else if (regIdx == `SCC_IDX_STABCNT) begin
			hitVec[H_SCNT] = 1'b1;
		end else if (regIdx == `SCC_IDX_SYSCLK) begin
			hitVec[H_SYS] = 1'b1;
		end else if (regIdx == `SCC_IDX_SUBSUP) begin
			hitVec[H_SUP] = 1'b1;
		end
	end

	// read data, status bits report the source really in use
	always @* begin
		rdByte = 8'h00;
		if (hitVec[H_OPT]) begin
			rdByte = optReg;
		end else if (hitVec[H_DIV]) begin
			rdByte = {5'h00, hocoDivReg};
		end else if (hitVec[H_MODE]) begin
			rdByte = {mainExtReg, mainPinReg, subExtReg, subPinReg, 1'b0, subDrvReg, mainGainReg};
		end else if (hitVec[H_SSEL]) begin
			rdByte = {5'h00, stabSelReg};
		end else if (hitVec[H_RUN]) begin
			rdByte = {mainStopReg, subStopReg, 5'h00, hocoStopReg};
		end else if (hitVec[H_SCNT]) begin
			rdByte = stabFlags;
		end else if (hitVec[H_SYS]) begin
			rdByte = {cpuClkSrc == `SCC_SRC_SUB, cpuSubSelReg, cpuClkSrc == `SCC_SRC_MAIN, mainSelReg, 4'h0};
		end else if (hitVec[H_SUP]) begin
			rdByte = {lowPwrReg, 2'h0, lsTmrReg, 4'h0};
		end
	end

	// answer captured in the setup phase; any unmapped access or a write to a read-only place flags an error
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel & ~penable) begin
			prdata  <= {24'h000000, rdByte};
			pslverr <= (hitVec == 8'h00) | (pwrite & (hitVec[H_OPT] | hitVec[H_SCNT]));
		end
	end

	// option byte caught once after reset release; a prohibited code falls back to 24 MHz
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			loadedReg      <= 1'b0;
			optReg         <= 8'h00;
			famReg         <= 1'b0;
			hocoDivReg     <= `SCC_RST_HOCO_DIVIDER_SELECT;
			flashHighSpeed <= 1'b0;
			optionError    <= 1'b0;
		end else if (!loadedReg) begin
			loadedReg      <= 1'b1;
			optReg         <= optionByte;
			famReg         <= (hocoMhz(optionByte[`SCC_OPT_FAM], optionByte[2:0]) != 5'd0) &
				optionByte[`SCC_OPT_FAM];
			hocoDivReg     <= (hocoMhz(optionByte[`SCC_OPT_FAM], optionByte[2:0]) != 5'd0) ?
				optionByte[2:0] : `SCC_RST_HOCO_DIVIDER_SELECT;
			flashHighSpeed <= optionByte[7:6] == `SCC_FLASH_HS;
			optionError    <= (hocoMhz(optionByte[`SCC_OPT_FAM], optionByte[2:0]) == 5'd0) |
				((optionByte[7:6] != `SCC_FLASH_LS) & (optionByte[7:6] != `SCC_FLASH_HS)) |
				~optionByte[`SCC_OPT_FIX1] | optionByte[`SCC_OPT_FIX0];
		end else if (wrByte0 & hitVec[H_DIV] & (hocoMhz(famReg, pwdata[2:0]) != 5'd0)) begin
			hocoDivReg     <= pwdata[2:0];
		end
	end

	// registers set to their reset values by every reset
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mainExtReg     <= 1'b0;
			mainPinReg     <= 1'b0;
			mainGainReg    <= 1'b0;
			modeWrittenReg <= 1'b0;
			mainStopReg    <= `SCC_RST_MAIN_STOP;
			hocoStopReg    <= `SCC_RST_HOCO_STOP;
			stabSelReg     <= `SCC_RST_STABSEL;
			cpuSubSelReg   <= 1'b0;
			mainSelReg     <= 1'b0;
			lowPwrReg      <= 1'b0;
			lsTmrReg       <= 1'b0;
		end else begin
			if (wrMode) begin
				mainExtReg     <= pwdata[`SCC_MODE_MAIN_EXT];
				mainPinReg     <= pwdata[`SCC_MODE_MAIN_PIN];
				mainGainReg    <= pwdata[`SCC_MODE_MAIN_GAIN];
				modeWrittenReg <= 1'b1;
			end
			if (wrByte0 & hitVec[H_RUN]) begin
				mainStopReg <= pwdata[`SCC_RUN_MAIN_STOP];
				hocoStopReg <= pwdata[`SCC_RUN_HOCO_STOP];
			end
			if (wrByte0 & hitVec[H_SSEL]) begin
				stabSelReg <= pwdata[2:0];
			end
			if (wrByte0 & hitVec[H_SYS]) begin
				cpuSubSelReg <= pwdata[`SCC_SYS_SUB_SEL];
				mainSelReg   <= pwdata[`SCC_SYS_MAIN_SEL];
			end
			if (wrByte0 & hitVec[H_SUP]) begin
				lowPwrReg <= pwdata[`SCC_SUP_LOWPWR];
				lsTmrReg  <= pwdata[`SCC_SUP_LSTMR];
			end
		end
	end

	// sub oscillator settings survive every reset but power-on
	always @(posedge clk_sys or negedge porN) begin
		if (!porN) begin
			subExtReg  <= 1'b0;
			subPinReg  <= 1'b0;
			subDrvReg  <= 2'h0;
			subStopReg <= `SCC_RST_SUB_STOP;
		end else begin
			if (wrMode) begin
				subExtReg <= pwdata[`SCC_MODE_SUB_EXT];
				subPinReg <= pwdata[`SCC_MODE_SUB_PIN];
				subDrvReg <= pwdata[`SCC_MODE_SUB_DRV_HI:`SCC_MODE_SUB_DRV_LO];
			end
			if (wrByte0 & hitVec[H_RUN]) begin
				subStopReg <= pwdata[`SCC_RUN_SUB_STOP];
			end
		end
	end

	// pin samplers; the first stage feeds only the second
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mainSyncReg <= 3'h0;
			subSyncReg  <= 3'h0;
		end else begin
			mainSyncReg <= {mainSyncReg[1:0], mainClkIn};
			subSyncReg  <= {subSyncReg[1:0], subClkIn};
		end
	end

	// stabilisation counter of main crystal periods, saturates at the last threshold
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			stabCntReg    <= 19'h00000;
			mainRunDlyReg <= 1'b0;
			stopDlyReg    <= 1'b0;
			mainHoldReg   <= 1'b0;
		end else begin
			mainRunDlyReg <= mainXtalRun;
			stopDlyReg    <= stopMode;
			if (!mainXtalRun || stabRestart) begin
				stabCntReg <= 19'h00000;
			end else if (mainEdge && stabCntReg != `SCC_STAB_MAX) begin
				stabCntReg <= stabCntReg + 19'h00001;
			end
			// the crystal clock stays gated after stop exit until the selected count
			if (mainXtalRun & stopDlyReg & ~stopMode) begin
				mainHoldReg <= 1'b1;
			end else if (mainHoldReg && (stabCntReg >= stabLimit || !mainXtalRun)) begin
				mainHoldReg <= 1'b0;
			end
		end
	end

	// status flags, bit 7 is the shortest threshold
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
			localparam [2:0] K = gi;
			assign stabFlags[7 - gi] = stabCntReg >= (`SCC_STAB_MAX >> (5'd18 - stabExp(K)));
		end
	endgenerate

	// internal oscillator as a fractional enable from the 100 MHz clock; pulses never exceed half rate
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			accReg       <= 7'h00;
			hocoPulseReg <= 1'b0;
		end else if (!hocoStopReg) begin
			if (accSum >= `SCC_SYS_MHZ) begin
				accReg       <= accSum[6:0] - `SCC_SYS_MHZ;
				hocoPulseReg <= 1'b1;
			end else begin
				accReg       <= accSum[6:0];
				hocoPulseReg <= 1'b0;
			end
		end else begin
			hocoPulseReg <= 1'b0;
		end
	end

	// oscillator controls and sub clock distribution
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mainXtalEnable <= 1'b0;
			mainExtEnable  <= 1'b0;
			mainHighGain   <= 1'b0;
			subXtalEnable  <= 1'b0;
			subExtEnable   <= 1'b0;
			subDriveMode   <= 2'h0;
			hocoEnable     <= 1'b0;
			lowOscEnable   <= 1'b0;
			hocoFreqMhz    <= 5'h00;
			subPeriphClkEn <= 1'b0;
			subCoreClkEn   <= 1'b0;
		end else begin
			mainXtalEnable <= mainXtalRun;
			mainExtEnable  <= mainExtRun;
			mainHighGain   <= mainGainReg & mainXtalRun;
			subXtalEnable  <= subRun & ~subExtReg;
			subExtEnable   <= subRun & subExtReg;
			subDriveMode   <= subExtReg ? 2'h0 : subDrvReg;
			hocoEnable     <= ~hocoStopReg;
			lowOscEnable   <= wdtRunning | lsTmrReg;
			hocoFreqMhz    <= hocoMhz(famReg, hocoDivReg);
			subPeriphClkEn <= subEdgeOk;
			// in stop or sub-halt the low power bit keeps the sub clock from the core side
			subCoreClkEn   <= subEdgeOk & ~(lowPwrReg & (stopMode | (haltMode & (cpuClkSrc == `SCC_SRC_SUB))));
		end
	end

	// glitch-free source change for the cpu clock enable
	scc_clk_switch u_switch (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.srcReq  (srcReq),
		.srcEdge ({subEdgeOk, mainEdgeOk, hocoPulseReg}),
		.clkEn   (cpuClkEn),
		.srcCur  (cpuClkSrc),
		.busy    ()
	);

endmodule

// ---- tb/scc_checker.sv ----
`timescale 1ns/100ps
`include "scc_map.vh"

module scc_checker (
	// system and bus
	input wire        clk_sys,
	input wire        nrst,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [21:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0]  pstrb,
	// watched outputs
	input wire [7:0]  optionByte,
	input wire        wdtRunning,
	input wire        mainXtalEnable,
	input wire        mainExtEnable,
	input wire        subXtalEnable,
	input wire        subExtEnable,
	input wire [1:0]  subDriveMode,
	input wire        hocoEnable,
	input wire        lowOscEnable,
	input wire        flashHighSpeed,
	input wire        optionError,
	input wire        cpuClkEn,
	input wire [1:0]  cpuClkSrc,
	input wire        subPeriphClkEn,
	input wire        subCoreClkEn
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// completed write to the run control register
	wire runWr = psel && penable && pwrite && pstrb[0] && (paddr[21:2] == `SCC_IDX_RUN);

	a_reset_hoco: assert property ($rose(nrst) |-> cpuClkSrc == `SCC_SRC_HOCO)
		else $error("source not internal after reset");
	a_flash_mode: assert property ($past(nrst) |-> flashHighSpeed == (optionByte[7:6] == `SCC_FLASH_HS))
		else $error("flash mode wrong");
	a_option_fixed: assert property ($past(nrst) && optionByte[5:4] != 2'h2 |-> optionError)
		else $error("fixed option bits not flagged");
	a_hoco_stop: assert property (runWr && pwdata[0] |-> ##[1:2] !hocoEnable)
		else $error("internal oscillator kept running");
	a_main_stop: assert property (runWr && pwdata[7] |-> ##[1:2] !mainXtalEnable && !mainExtEnable)
		else $error("main oscillator kept running");
	a_sub_stop: assert property (runWr && pwdata[6] |-> ##[1:2] !subXtalEnable && !subExtEnable)
		else $error("sub oscillator kept running");
	a_switch_quiet: assert property ($changed(cpuClkSrc) |-> !cpuClkEn)
		else $error("clock pulse at source handover");
	a_sub_drive_ext: assert property (subExtEnable |-> subDriveMode == 2'h0)
		else $error("drive mode used with external sub clock");
	a_core_subset: assert property (subCoreClkEn |-> subPeriphClkEn)
		else $error("core sub pulse without sub edge");
	a_low_osc: assert property (wdtRunning |-> ##[1:2] lowOscEnable)
		else $error("low-speed oscillator off with watchdog");

	c_on_main: cover property (cpuClkSrc == `SCC_SRC_MAIN);
	c_on_sub: cover property (cpuClkSrc == `SCC_SRC_SUB);
	c_run_write: cover property (runWr);
endmodule

bind scc_top scc_checker chk_u (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.optionByte, .wdtRunning, .mainXtalEnable, .mainExtEnable, .subXtalEnable, .subExtEnable,
	.subDriveMode, .hocoEnable, .lowOscEnable, .flashHighSpeed, .optionError, .cpuClkEn,
	.cpuClkSrc, .subPeriphClkEn, .subCoreClkEn);

// ---- tb/scc_osc_model.sv ----
`timescale 1ns/100ps

module scc_osc_model (
	// oscillator controls
	input  wire  mainXtalEnable,
	input  wire  mainExtEnable,
	input  wire  subXtalEnable,
	input  wire  subExtEnable,
	// oscillator pins
	output logic mainClkIn,
	output logic subClkIn
);
	initial mainClkIn = 1'h0;
	initial subClkIn = 1'h0;
	// pins toggle only while enabled and rest low otherwise, so a stopped source shows no edges
	always #21 mainClkIn = (mainXtalEnable || mainExtEnable) ? ~mainClkIn : 1'h0;
	always #163 subClkIn = (subXtalEnable || subExtEnable) ? ~subClkIn : 1'h0;
endmodule

// ---- tb/system_clock_source_control_bench.sv ----
`timescale 1ns/100ps
`include "scc_map.vh"

module system_clock_source_control_bench;
	// stimulus
	logic        clk_sys = 1'h0, nrst = 1'h0, porN = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic        stopMode = 1'h0, haltMode = 1'h0, wdtRunning = 1'h0;
	logic [21:0] paddr = 22'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [7:0]  optionByte = 8'he0;
	// observed
	wire  [31:0] prdata;
	wire         pready, pslverr, mainClkIn, subClkIn, mainXtalEnable, mainExtEnable, mainHighGain;
	wire         subXtalEnable, subExtEnable, hocoEnable, lowOscEnable, flashHighSpeed, optionError;
	wire         cpuClkEn, subPeriphClkEn, subCoreClkEn;
	wire  [1:0]  subDriveMode, cpuClkSrc;
	wire  [4:0]  hocoFreqMhz;
	// bench state
	integer      err_count = 0, n_compared = 0, i, f, j, j2;
	logic [7:0]  rnd = 8'h1c;
	logic [31:0] rd;
	logic [4:0]  mhz;
	logic        er;

	scc_top dut_u (.clk_sys, .nrst, .porN, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .optionByte, .mainClkIn, .subClkIn, .stopMode, .haltMode, .wdtRunning,
		.mainXtalEnable, .mainExtEnable, .mainHighGain, .subXtalEnable, .subExtEnable, .subDriveMode,
		.hocoEnable, .lowOscEnable, .hocoFreqMhz, .flashHighSpeed, .optionError, .cpuClkEn, .cpuClkSrc,
		.subPeriphClkEn, .subCoreClkEn);
	scc_osc_model osc_u (.mainXtalEnable, .mainExtEnable, .subXtalEnable, .subExtEnable, .mainClkIn, .subClkIn);

	always #5 clk_sys = ~clk_sys;

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// internal frequency for an option code; prohibited codes fall back to 24 MHz
	function automatic logic [4:0] opt_mhz(input logic [3:0] c);
		case (c)
			4'h9: return 5'h10;
			4'h1: return 5'hc;
			4'ha: return 5'h8;
			4'h2: return 5'h6;
			4'hb: return 5'h4;
			4'h3: return 5'h3;
			4'hc: return 5'h2;
			4'hd: return 5'h1;
			default: return 5'h18;
		endcase
	endfunction
	// divider result within a family; prohibited values leave the frequency alone
	function automatic logic [4:0] div_mhz(input logic fam, input logic [2:0] d, input logic [4:0] prev);
		if (!fam && d < 3'h4)
			return 5'h18 >> d;
		if (fam && d != 3'h0 && d < 3'h6)
			return 5'h10 >> (d - 3'h1);
		return prev;
	endfunction

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task final_report;
		$display("compared %0d mismatched %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// one apb transfer: setup, then access held until pready is seen high
	task apb(input logic w, input logic [19:0] idx, input logic [7:0] d, input logic [3:0] s);
		integer k;
		@(posedge clk_sys);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge clk_sys);
		penable <= 1'h1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_sys);
			if (pready === 1'h1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (k == 20) begin
			chk("pready", 1, 0);
			final_report;
		end
	endtask
	task wr(input logic [19:0] idx, input logic [7:0] d);
		apb(1'h1, idx, d, 4'h1);
	endtask
	task rdchk(input logic [19:0] idx, input logic [7:0] e, input string nm);
		apb(1'h0, idx, 8'h0, 4'h0);
		chk(nm, {24'h0, e}, rd);
	endtask
	// reset with a new option byte; por also clears the sub oscillator settings
	task do_reset(input logic por, input logic [7:0] opt);
		@(posedge clk_sys);
		nrst <= 1'h0;
		porN <= !por;
		optionByte <= opt;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'h1;
		porN <= 1'h1;
		repeat (3) @(posedge clk_sys);
	endtask
	task wait_src(input logic [1:0] s);
		integer k;
		for (k = 0; k < 3000 && cpuClkSrc !== s; k++)
			@(posedge clk_sys);
		chk("cpuClkSrc", s, cpuClkSrc);
		if (cpuClkSrc !== s)
			final_report;
	endtask

	// hang guard
	initial begin
		#900000;
		chk("watchdog", 0, 1);
		final_report;
	end

	initial begin
		// every option code, flash mode drawn at random
		for (i = 0; i < 16; i++) begin
			rnd = lfsr(rnd);
			do_reset(1'h1, {1'h1, rnd[0], 2'h2, i[3:0]});
			chk("cpuClkSrc", 0, cpuClkSrc);
			chk("hocoEnable", 1, hocoEnable);
			chk("hocoFreqMhz", opt_mhz(i[3:0]), hocoFreqMhz);
			chk("flashHighSpeed", rnd[0], flashHighSpeed);
			chk("optionError", !(i inside {0, 1, 2, 3, 9, 10, 11, 12, 13}), optionError);
		end
		do_reset(1'h1, 8'h90);
		chk("optionError", 1, optionError);
		do_reset(1'h1, 8'h60);
		chk("optionError", 1, optionError);
		$display("option test done");
		// random divider values in both families
		for (f = 0; f < 2; f++) begin
			do_reset(1'h1, f ? 8'he9 : 8'he0);
			mhz = f ? 5'h10 : 5'h18;
			for (i = 0; i < 14; i++) begin
				rnd = lfsr(rnd);
				wr(`SCC_IDX_HOCO_DIVIDER_SELECT, {5'h0, rnd[2:0]});
				mhz = div_mhz(f[0], rnd[2:0], mhz);
				repeat (3) @(posedge clk_sys);
				chk("hocoFreqMhz", mhz, hocoFreqMhz);
			end
		end
		$display("divider test done");
		// reset values, unmapped and read-only places
		do_reset(1'h1, 8'he0);
		rdchk(`SCC_IDX_RUN, 8'hc0, "run");
		rdchk(`SCC_IDX_STABSEL, 8'h07, "stabsel");
		rdchk(`SCC_IDX_MODE, 8'h00, "mode");
		rdchk(`SCC_IDX_SYSCLK, 8'h00, "sysclk");
		rdchk(`SCC_IDX_STABCNT, 8'h00, "stabcnt");
		apb(1'h0, 20'h12345, 8'h0, 4'h0);
		chk("unmappedErr", 1, er);
		apb(1'h1, `SCC_IDX_STABCNT, 8'hff, 4'h1);
		chk("readOnlyErr", 1, er);
		// mode register: wrong strobes refused, then one write only
		apb(1'h1, `SCC_IDX_MODE, 8'h80, 4'hf);
		wr(`SCC_IDX_MODE, 8'h52);
		wr(`SCC_IDX_MODE, 8'hc0);
		rdchk(`SCC_IDX_MODE, 8'h52, "mode");
		wr(`SCC_IDX_RUN, 8'hc1);
		repeat (2) @(posedge clk_sys);
		chk("hocoEnable", 0, hocoEnable);
		$display("register test done");
		// main crystal: wait select, start, poll count, then switch
		wr(`SCC_IDX_STABSEL, 8'h00);
		wr(`SCC_IDX_RUN, 8'h40);
		repeat (2) @(posedge clk_sys);
		chk("mainXtalEnable", 1, mainXtalEnable);
		chk("mainExtEnable", 0, mainExtEnable);
		chk("hocoEnable", 1, hocoEnable);
		rd = 32'h0;
		for (i = 0; i < 600 && rd === 32'h0; i++)
			apb(1'h0, `SCC_IDX_STABCNT, 8'h0, 4'h0);
		chk("stabCount", 8'h80, rd);
		wr(`SCC_IDX_SYSCLK, 8'h10);
		wait_src(`SCC_SRC_MAIN);
		rdchk(`SCC_IDX_SYSCLK, 8'h30, "sysclk");
		wr(`SCC_IDX_SYSCLK, 8'h00);
		wait_src(`SCC_SRC_HOCO);
		wr(`SCC_IDX_RUN, 8'hc0);
		repeat (2) @(posedge clk_sys);
		chk("mainXtalEnable", 0, mainXtalEnable);
		$display("main clock test done");
		// sub crystal, stabilisation timed by software
		wr(`SCC_IDX_RUN, 8'h80);
		repeat (2) @(posedge clk_sys);
		chk("subXtalEnable", 1, subXtalEnable);
		chk("subDriveMode", 1, subDriveMode);
		repeat (300) @(posedge clk_sys);
		wr(`SCC_IDX_SUBSUP, 8'h80);
		wr(`SCC_IDX_SYSCLK, 8'h40);
		wait_src(`SCC_SRC_SUB);
		rdchk(`SCC_IDX_SYSCLK, 8'hc0, "sysclk");
		// stop mode with the low-power bit: only the peripheral side keeps the sub clock
		stopMode <= 1'h1;
		j = 0;
		j2 = 0;
		for (i = 0; i < 120; i++) begin
			@(posedge clk_sys);
			j += (subCoreClkEn === 1'h1);
			j2 += (subPeriphClkEn === 1'h1);
		end
		stopMode <= 1'h0;
		chk("coreSubPulses", 0, j);
		chk("periphSubLive", 1, j2 > 0);
		wr(`SCC_IDX_SYSCLK, 8'h00);
		wait_src(`SCC_SRC_HOCO);
		$display("sub clock test done");
		// warm reset keeps sub settings, power-on clears them
		do_reset(1'h0, 8'he0);
		chk("cpuClkSrc", 0, cpuClkSrc);
		rdchk(`SCC_IDX_MODE, 8'h12, "mode");
		rdchk(`SCC_IDX_RUN, 8'h80, "run");
		do_reset(1'h1, 8'he0);
		rdchk(`SCC_IDX_MODE, 8'h00, "mode");
		rdchk(`SCC_IDX_RUN, 8'hc0, "run");
		// high gain and external sub clock: drive mode output must be zero
		wr(`SCC_IDX_MODE, 8'h77);
		wr(`SCC_IDX_RUN, 8'h00);
		repeat (2) @(posedge clk_sys);
		chk("mainHighGain", 1, mainHighGain);
		chk("subExtEnable", 1, subExtEnable);
		chk("subDriveMode", 0, subDriveMode);
		// low-speed oscillator follows watchdog and timer clock select
		wdtRunning <= 1'h1;
		repeat (3) @(posedge clk_sys);
		chk("lowOscEnable", 1, lowOscEnable);
		wdtRunning <= 1'h0;
		repeat (3) @(posedge clk_sys);
		chk("lowOscEnable", 0, lowOscEnable);
		wr(`SCC_IDX_SUBSUP, 8'h10);
		repeat (3) @(posedge clk_sys);
		chk("lowOscEnable", 1, lowOscEnable);
		$display("reset and low-speed test done");
		final_report;
	end
endmodule
